// ==== rtl/bpwm_channel.sv ====
// Buffered PWM channel with Wishbone registers and counter bus
`timescale 1ns/1ps
module bpwm_channel #(
   parameter int CNT_W = bpwm_pkg::CNT_W,
   parameter int PRE_W = bpwm_pkg::PRE_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic output_disable_enable_i,
   input wire logic [CNT_W-1:0] cnt_bus_i,
   output logic [CNT_W-1:0] cnt_bus_o,
   output logic pwm_o,
   output logic flag_o
);

   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
   localparam logic [CNT_W-1:0] MAXV = '1;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (dat & m);
   endfunction : merge

   bpwm_pkg::bpwm_ctrl_t ctrl_q;
   logic [CNT_W-1:0] sh_a_q;
   logic [CNT_W-1:0] sh_b_q;
   logic [CNT_W-1:0] act_a_q;
   logic [CNT_W-1:0] act_b_q;
   logic [CNT_W-1:0] cnt_q;
   logic dir_down_q;
   logic phase_q;
   logic ma_q;
   logic mb_q;
   logic one_q;
   logic out_q;
   logic flag_q;
   logic output_disable_enable_s1_q;
   logic output_disable_enable_s2_q;
   logic ack_q;
   logic [31:0] dat_q;

   logic req;
   logic wr_en;
   logic [31:0] wr_ctrl;
   logic [31:0] wr_sh_a;
   logic [31:0] wr_sh_b;
   logic frc_a;
   logic frc_b;
   logic flag_clr;
   logic tick;
   logic is_fwm;
   logic is_cen;
   logic is_mcb;
   logic [CNT_W-1:0] tb;
   logic ld;
   logic upd;
   logic [CNT_W-1:0] a_eff;
   logic a_zero;
   logic [CNT_W-1:0] a_cmp;
   logic ma;
   logic mb;
   logic ev_a;
   logic ev_b;
   logic output_disable_enable_act;
   logic flag_set;

   // Wishbone slave: ack one cycle after the request, write at ack edge
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_en = req & wb_we_i & ack_q;
   assign wr_ctrl = merge({16'h0000, ctrl_q}, wb_dat_i, wb_sel_i);
   assign wr_sh_a = merge({8'h00, sh_a_q}, wb_dat_i, wb_sel_i);
   assign wr_sh_b = merge({8'h00, sh_b_q}, wb_dat_i, wb_sel_i);
   assign frc_a = wr_en && wb_adr_i == bpwm_pkg::OFS_FORCE && wb_sel_i[0]
                  && wb_dat_i[bpwm_pkg::FRC_A_BIT];
   assign frc_b = wr_en && wb_adr_i == bpwm_pkg::OFS_FORCE && wb_sel_i[0]
                  && wb_dat_i[bpwm_pkg::FRC_B_BIT];
   assign flag_clr = wr_en && wb_adr_i == bpwm_pkg::OFS_STATUS
                     && wb_sel_i[0] && wb_dat_i[bpwm_pkg::STAT_FLAG_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h00000000;
      end else if (req && !ack_q) begin
         unique case (wb_adr_i)
            bpwm_pkg::OFS_CTRL: dat_q <= {16'h0000, ctrl_q};
            bpwm_pkg::OFS_SHADOW_A: dat_q <= 32'(sh_a_q);
            bpwm_pkg::OFS_SHADOW_B: dat_q <= 32'(sh_b_q);
            bpwm_pkg::OFS_ACTIVE_A: dat_q <= 32'(act_a_q);
            bpwm_pkg::OFS_ACTIVE_B: dat_q <= 32'(act_b_q);
            bpwm_pkg::OFS_COUNT: dat_q <= 32'(cnt_q);
            bpwm_pkg::OFS_STATUS: dat_q <= {30'h00000000, out_q, flag_q};
            default: dat_q <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= bpwm_pkg::bpwm_ctrl_t'(bpwm_pkg::CTRL_RST);
         sh_a_q <= bpwm_pkg::CMP_RST;
         sh_b_q <= bpwm_pkg::CMP_RST;
      end else if (wr_en) begin
         if (wb_adr_i == bpwm_pkg::OFS_CTRL) begin
            ctrl_q <= bpwm_pkg::bpwm_ctrl_t'(wr_ctrl[15:0]);
         end
         if (wb_adr_i == bpwm_pkg::OFS_SHADOW_A) begin
            sh_a_q <= wr_sh_a[CNT_W-1:0];
         end
         if (wb_adr_i == bpwm_pkg::OFS_SHADOW_B) begin
            sh_b_q <= wr_sh_b[CNT_W-1:0];
         end
      end
   end

   // Output disable is an asynchronous pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         output_disable_enable_s1_q <= 1'b0;
         output_disable_enable_s2_q <= 1'b0;
      end else begin
         output_disable_enable_s1_q <= output_disable_enable_i;
         output_disable_enable_s2_q <= output_disable_enable_s1_q;
      end
   end

   // Counter advances only on prescaler ticks
   bpwm_prescaler #(
      .PRE_W(PRE_W)
   ) u_presc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(~ctrl_q.en),
      .ratio_i(PRE_W'(ctrl_q.presc)),
      .tick_o(tick)
   );

   assign is_fwm = ctrl_q.en && ctrl_q.mode == bpwm_pkg::MODE_FREQ_DUTY;
   assign is_cen = ctrl_q.en && ctrl_q.mode == bpwm_pkg::MODE_CENTER;
   assign is_mcb = ctrl_q.en && ctrl_q.mode == bpwm_pkg::MODE_MODULUS;
   assign output_disable_enable_act = output_disable_enable_s2_q & ctrl_q.output_disable_enable_en;

   // Cycle boundary: first clock with the time base at one
   assign tb = is_cen ? cnt_bus_i : cnt_q;
   assign ld = ctrl_q.en && tb == ONE && !one_q;
   assign upd = ld & ~ctrl_q.upd_dis;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         one_q <= 1'b0;
      end else begin
         // Gated by enable so the first enabled clock at one still loads
         one_q <= ctrl_q.en && tb == ONE;
      end
   end

   // Active registers change one clock after the pulse starts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_a_q <= bpwm_pkg::CMP_RST;
         act_b_q <= bpwm_pkg::CMP_RST;
      end else if (upd) begin
         act_a_q <= sh_a_q;
         if (!is_mcb) begin
            act_b_q <= sh_b_q;
         end
      end
   end

   // During the pulse a shadow of 0 or 1 is compared directly
   assign a_eff = (upd && sh_a_q <= ONE) ? sh_a_q : act_a_q;
   assign a_zero = is_fwm && a_eff == '0;
   // Counter never reaches zero, so zero is matched at one
   assign a_cmp = a_zero ? ONE : a_eff;

   // A on the bus in center mode, else the own counter
   assign ma = is_cen ? (cnt_bus_i == a_cmp) : (cnt_q == a_cmp);
   assign mb = (is_fwm || is_cen) && cnt_q == act_b_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ma_q <= 1'b0;
         mb_q <= 1'b0;
      end else begin
         ma_q <= ma;
         mb_q <= mb;
      end
   end

   // Events on match negation, except A zero uses its rise
   assign ev_a = a_zero ? (ma & ~ma_q) : (ma_q & ~ma);
   assign ev_b = mb_q & ~mb;

   // Internal counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= bpwm_pkg::CNT_RST;
         dir_down_q <= 1'b0;
      end else if (is_fwm) begin
         dir_down_q <= 1'b0;
         if (frc_b) begin
            cnt_q <= ONE;
         end else if (tick) begin
            if (cnt_q >= act_b_q) begin
               cnt_q <= ONE;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end else if (is_cen) begin
         dir_down_q <= 1'b0;
         if (ev_a) begin
            cnt_q <= ONE;
         end else if (tick && cnt_q != MAXV) begin
            // Saturates so a long gap cannot wrap into a false B match
            cnt_q <= cnt_q + 1'b1;
         end
      end else if (is_mcb) begin
         if (tick) begin
            if (!dir_down_q && cnt_q >= act_a_q) begin
               dir_down_q <= 1'b1;
               cnt_q <= (cnt_q > ONE) ? cnt_q - 1'b1 : ONE;
            end else if (dir_down_q && cnt_q <= ONE) begin
               dir_down_q <= 1'b0;
               cnt_q <= (act_a_q > ONE) ? cnt_q + 1'b1 : ONE;
            end else if (dir_down_q) begin
               cnt_q <= cnt_q - 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end else begin
         cnt_q <= bpwm_pkg::CNT_RST;
         dir_down_q <= 1'b0;
      end
   end

   // A matches alternate; phase is high between first and second match
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_q <= 1'b0;
      end else if (!is_cen) begin
         phase_q <= 1'b0;
      end else if (ev_a) begin
         phase_q <= ~phase_q;
      end
   end

   // Output register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
      end else if (is_fwm) begin
         if (output_disable_enable_act) begin
            out_q <= ctrl_q.pol;
         end else if (frc_b) begin
            out_q <= ~ctrl_q.pol;
         end else if (frc_a) begin
            out_q <= ctrl_q.pol;
         end else if (ev_a && a_zero) begin
            out_q <= ctrl_q.pol;
         end else if (ev_b) begin
            out_q <= ~ctrl_q.pol;
         end else if (ev_a) begin
            out_q <= ctrl_q.pol;
         end
      end else if (is_cen) begin
         if (output_disable_enable_act) begin
            // Center mode falls back to the inactive level
            out_q <= ~ctrl_q.pol;
         end else if (frc_b) begin
            out_q <= ~ctrl_q.pol;
         end else if (frc_a) begin
            out_q <= ctrl_q.pol;
         end else if (ctrl_q.dt_lead) begin
            // Only the first A match of a pair arms B
            if (ev_a && phase_q) begin
               out_q <= ~ctrl_q.pol;
            end else if (ev_b && phase_q) begin
               out_q <= ctrl_q.pol;
            end
         end else begin
            // Second A arms B; a late B after the next first A is masked
            if (ev_a && !phase_q) begin
               out_q <= ctrl_q.pol;
            end else if (ev_b && !phase_q) begin
               out_q <= ~ctrl_q.pol;
            end
         end
      end
   end

   // Flag sources per mode; forces never set it
   always_comb begin
      flag_set = 1'b0;
      if (is_fwm) begin
         flag_set = ev_b | (ctrl_q.flag_sel & ev_a);
      end else if (is_cen && ctrl_q.dt_lead) begin
         flag_set = phase_q & (ev_a | (ctrl_q.flag_sel & ev_b));
      end else if (is_cen) begin
         flag_set = ~phase_q & (ev_b | (ctrl_q.flag_sel & ev_a));
      end else if (is_mcb) begin
         flag_set = ev_a | (ctrl_q.flag_sel & ld);
      end
   end

   // A set in the same cycle as the clear wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= 1'b0;
      end else if (flag_set) begin
         flag_q <= 1'b1;
      end else if (flag_clr) begin
         flag_q <= 1'b0;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign pwm_o = out_q;
   assign flag_o = flag_q;
   assign cnt_bus_o = cnt_q;

endmodule : bpwm_channel

// ==== rtl/bpwm_pkg.sv ====
// Package for the buffered PWM channel: register map, fields, modes
// Summary of operation
// - Freq-duty mode: own counter, A width, B period
// - Freq-duty counter runs 1 up to B, never zero
// - A match drives polarity, B match its inverse
// - B match reloads internal counter with one
// - Output changes on match falling edge
// - A zero: rising edge at one, masks B
// - Counter at one: one-clock load pulse, shadows copied
// - Update-disable bit blocks shadow to active copy
// - Old A during pulse; shadow 0/1 bypasses
// - Flag on B, or both when flag-select set
// - Output disable forces polarity; resumes on match
// - Force bits set level, no flag; B reloads counter with one
// - Coincident matches: B wins; A>=B gives 0%
// - Center: A versus bus, B versus internal counter
// - Mode bit picks leading or trailing dead time
// - Center: load both when bus reaches one
// - Center: update-disable blocks both loads
// - Center: every A match reloads counter with one
// - Leading: B match polarity, next A inverse
// - Modulus master counts up to A, down to one
package bpwm_pkg;

   localparam int CNT_W = 24;
   localparam int PRE_W = 8;

   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_FREQ_DUTY,
      MODE_CENTER,
      MODE_MODULUS
   } bpwm_mode_t;

   typedef struct packed {
      logic [7:0] presc;
      logic upd_dis;
      logic output_disable_enable_en;
      logic dt_lead;
      logic flag_sel;
      logic pol;
      bpwm_mode_t mode;
      logic en;
   } bpwm_ctrl_t;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SHADOW_A = 8'h04;
   localparam logic [7:0] OFS_SHADOW_B = 8'h08;
   localparam logic [7:0] OFS_ACTIVE_A = 8'h0c;
   localparam logic [7:0] OFS_ACTIVE_B = 8'h10;
   localparam logic [7:0] OFS_COUNT = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_FORCE = 8'h1c;

   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_OUT_BIT = 1;
   localparam int FRC_A_BIT = 0;
   localparam int FRC_B_BIT = 1;

   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CMP_RST = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_RST = 24'h000001;

endpackage : bpwm_pkg

// ==== rtl/bpwm_prescaler.sv ====
// Prescaler that turns the system clock into a one-cycle count enable
`timescale 1ns/1ps
module bpwm_prescaler #(
   parameter int PRE_W = bpwm_pkg::PRE_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic [PRE_W-1:0] ratio_i,
   output logic tick_o
);

   logic [PRE_W-1:0] cnt_q;

   // Ratio value r divides by r+1; clear keeps it in phase with enable
   assign tick_o = (cnt_q >= ratio_i);

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i || tick_o) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule : bpwm_prescaler

// ==== sim/bpwm_bus_model.sv ====
// Up/down modulus counter driving the shared counter bus
`timescale 1ns/1ps
module bpwm_bus_model #(
   parameter int PER = 10
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic [23:0] cnt_o
);
   logic [23:0] cnt_q;
   logic up_q;
   assign cnt_o = cnt_q;
   // Same clock, no prescale, so both sides share one time scale
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 24'h000001;
         up_q <= 1'b1;
      end else if (up_q) begin
         up_q <= (cnt_q < 24'(PER));
         cnt_q <= (cnt_q < 24'(PER)) ? cnt_q + 24'h000001 : cnt_q - 24'h000001;
      end else begin
         up_q <= (cnt_q <= 24'h000002);
         cnt_q <= cnt_q - 24'h000001;
      end
   end
endmodule : bpwm_bus_model

// ==== sim/bpwm_channel_properties.sv ====
// Port checker for the buffered PWM channel
`timescale 1ns/1ps
module bpwm_channel_properties #(
   parameter int CNT_W = 24,
   parameter int PRE_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic output_disable_enable_i,
   input wire logic [CNT_W-1:0] cnt_bus_i,
   input wire logic [CNT_W-1:0] cnt_bus_o,
   input wire logic pwm_o,
   input wire logic flag_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack missing after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |->
      $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   AST_DAT_HOLD: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved outside ack");
   AST_RST_VAL: assert property (disable iff (1'b0) rst_i |=>
      cnt_bus_o == 24'h000001 && !pwm_o && !flag_o)
      else $error("bad values in reset");
   AST_CNT_NZ: assert property (cnt_bus_o != 24'h000000)
      else $error("counter reached zero");
   AST_CNT_STEP: assert property ($changed(cnt_bus_o) |->
      cnt_bus_o == 24'h000001 || cnt_bus_o == $past(cnt_bus_o) + 24'h000001
      || cnt_bus_o == $past(cnt_bus_o) - 24'h000001)
      else $error("counter jumped");
   AST_FLAG_CLR: assert property ($fell(flag_o) |->
      $past(wb_ack_o && wb_we_i && wb_dat_i[0])
      && $past(wb_adr_i) == bpwm_pkg::OFS_STATUS)
      else $error("flag dropped without clear");

   // Main scenarios reached
   cover property ($rose(flag_o));
   cover property ($rose(pwm_o));
   cover property ($past(cnt_bus_o) > 24'h000001 && cnt_bus_o == 24'h000001);
endmodule : bpwm_channel_properties

bind bpwm_channel bpwm_channel_properties #(.CNT_W(CNT_W), .PRE_W(PRE_W))
   bpwm_channel_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .output_disable_enable_i(output_disable_enable_i),
   .cnt_bus_i(cnt_bus_i), .cnt_bus_o(cnt_bus_o), .pwm_o(pwm_o),
   .flag_o(flag_o));

// ==== sim/bpwm_channel_tb.sv ====
// Self-checking bench for the buffered PWM channel
`timescale 1ns/1ps
module bpwm_channel_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic output_disable_enable = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat, rd;
   logic ack, pwm, flag;
   logic [23:0] bus, cnt;
   int err_total = 0;
   int tests_run = 0;
   int hi, rs, hl, rl, ex;
   int av [6] = '{2, 0, 1, 3, 4, 6};
   logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
      8'h18, 8'h1c, 8'h20};

   always #5 clk_i = ~clk_i;

   bpwm_bus_model #(.PER(10)) bpwm_bus_model_inst (.clk_i(clk_i),
      .rst_i(rst_i), .cnt_o(bus));
   bpwm_channel bpwm_channel_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .output_disable_enable_i(output_disable_enable), .cnt_bus_i(bus), .cnt_bus_o(cnt), .pwm_o(pwm),
      .flag_o(flag));

   task automatic test_done();
      $display("tests_run=%0d err_total=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Holds the request until ack is sampled, releases at that edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 20) err_total++;
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h00000000);
      chk(rd, e);
   endtask : rchk

   task automatic setc(input logic [7:0] ps, input logic [4:0] b,
                       input bpwm_pkg::bpwm_mode_t m);
      wb(1'b1, bpwm_pkg::OFS_CTRL, {16'h0000, ps, b, m, 1'b1});
   endtask : setc

   task automatic wcnt(input logic [23:0] v);
      int n;
      n = 0;
      while (cnt !== v && n < 1000) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 1000) err_total++;
   endtask : wcnt

   // High cycles and rising edges over a window of n clocks
   task automatic meas(input int n, output int h, output int r);
      logic p;
      h = 0;
      r = 0;
      p = pwm;
      repeat (n) begin
         @(posedge clk_i);
         h += int'(pwm === 1'b1);
         r += int'(pwm === 1'b1 && p === 1'b0);
         p = pwm;
      end
   endtask : meas

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ofs[i]) rchk(ofs[i], (i == 5) ? 32'h1 : 32'h0);
      wb(1'b1, bpwm_pkg::OFS_ACTIVE_A, 32'h00000005);
      wb(1'b1, 8'h20, 32'h00000005);
      rchk(bpwm_pkg::OFS_ACTIVE_A, 32'h00000000);
      rchk(8'h20, 32'h00000000);
      $display("test reset done");
      wb(1'b1, bpwm_pkg::OFS_SHADOW_B, 32'h00000004);
      wb(1'b1, bpwm_pkg::OFS_SHADOW_A, 32'h00000002);
      setc(8'h00, 5'b00001, bpwm_pkg::MODE_FREQ_DUTY);
      repeat (10) @(posedge clk_i);
      rchk(bpwm_pkg::OFS_ACTIVE_A, 32'h00000002);
      rchk(bpwm_pkg::OFS_ACTIVE_B, 32'h00000004);
      chk(32'(flag), 32'h1);
      foreach (av[i]) begin
         wb(1'b1, bpwm_pkg::OFS_SHADOW_A, av[i]);
         repeat (12) @(posedge clk_i);
         meas(40, hi, rs);
         ex = av[i] == 0 ? 40 : av[i] >= 4 ? 0 : 10 * (4 - av[i]);
         chk(hi, ex);
         chk(rs, (av[i] == 0 || av[i] >= 4) ? 0 : 10);
      end
      $display("test duty done");
      wb(1'b1, bpwm_pkg::OFS_SHADOW_B, 32'h000000c8);
      wb(1'b1, bpwm_pkg::OFS_SHADOW_A, 32'h00000032);
      for (int f = 0; f < 2; f++) begin
         setc(8'h00, {3'b000, f[0], 1'b1}, bpwm_pkg::MODE_FREQ_DUTY);
         wcnt(24'h00000a);
         wb(1'b1, bpwm_pkg::OFS_STATUS, 32'h00000001);
         wcnt(24'h000064);
         chk(32'(flag), f);
      end
      $display("test flag done");
      setc(8'h00, 5'b10001, bpwm_pkg::MODE_FREQ_DUTY);
      wb(1'b1, bpwm_pkg::OFS_SHADOW_A, 32'h0000004d);
      repeat (450) @(posedge clk_i);
      rchk(bpwm_pkg::OFS_ACTIVE_A, 32'h00000032);
      setc(8'h00, 5'b00001, bpwm_pkg::MODE_FREQ_DUTY);
      repeat (450) @(posedge clk_i);
      rchk(bpwm_pkg::OFS_ACTIVE_A, 32'h0000004d);
      $display("test update done");
      wb(1'b1, bpwm_pkg::OFS_SHADOW_A, 32'h000000fa);
      repeat (450) @(posedge clk_i);
      chk(32'(pwm), 32'h0);
      wcnt(24'h00000a);
      wb(1'b1, bpwm_pkg::OFS_STATUS, 32'h00000001);
      wb(1'b1, bpwm_pkg::OFS_FORCE, 32'h00000001);
      repeat (2) @(posedge clk_i);
      chk(32'(pwm), 32'h1);
      wb(1'b1, bpwm_pkg::OFS_FORCE, 32'h00000002);
      repeat (2) @(posedge clk_i);
      chk(32'(pwm), 32'h0);
      chk(32'(cnt < 24'h000008), 32'h1);
      chk(32'(flag), 32'h0);
      $display("test force done");
      setc(8'h00, 5'b01001, bpwm_pkg::MODE_FREQ_DUTY);
      output_disable_enable <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk(32'(pwm), 32'h1);
      output_disable_enable <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk(32'(pwm), 32'h1);
      wcnt(24'h000005);
      chk(32'(pwm), 32'h0);
      $display("test disable done");
      wb(1'b1, bpwm_pkg::OFS_SHADOW_B, 32'h00000004);
      wb(1'b1, bpwm_pkg::OFS_SHADOW_A, 32'h00000002);
      setc(8'h01, 5'b00001, bpwm_pkg::MODE_FREQ_DUTY);
      repeat (500) @(posedge clk_i);
      meas(48, hi, rs);
      chk(hi, 24);
      chk(rs, 6);
      $display("test prescale done");
      wb(1'b1, bpwm_pkg::OFS_SHADOW_A, 32'h00000006);
      wb(1'b1, bpwm_pkg::OFS_SHADOW_B, 32'h00000002);
      setc(8'h00, 5'b00101, bpwm_pkg::MODE_CENTER);
      repeat (60) @(posedge clk_i);
      rchk(bpwm_pkg::OFS_ACTIVE_B, 32'h00000002);
      meas(72, hl, rl);
      chk(rl, 4);
      setc(8'h00, 5'b00001, bpwm_pkg::MODE_CENTER);
      repeat (60) @(posedge clk_i);
      meas(72, hi, rs);
      chk(32'(hi > hl), 32'h1);
      $display("test center done");
      wb(1'b1, bpwm_pkg::OFS_SHADOW_A, 32'h00000004);
      setc(8'h00, 5'b00001, bpwm_pkg::MODE_MODULUS);
      wcnt(24'h000001);
      @(posedge clk_i);
      chk(32'(cnt), 32'h00000002);
      wcnt(24'h000004);
      @(posedge clk_i);
      chk(32'(cnt), 32'h00000003);
      $display("test modulus done");
      test_done();
   end

   // Tests need about 3400 clocks; cut a hang well beyond that
   initial begin
      #500000;
      err_total++;
      test_done();
   end
endmodule : bpwm_channel_tb
